// File: hdl/alfc_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: plain register port, byte offsets one word apart
// Notes:   definitions only
`ifndef ALFC_MAP_SVH
`define ALFC_MAP_SVH

`define ALFC_ADDR_W           8
`define ALFC_OFS_THIRD_POLE   8'h00
`define ALFC_OFS_LOCK_CFG     8'h04
`define ALFC_OFS_THRESH       8'h08
`define ALFC_OFS_VCO_CAL      8'h0c
`define ALFC_OFS_IRQ_STATUS   8'h10
`define ALFC_OFS_IRQ_CLEAR    8'h14
`define ALFC_OFS_IRQ_ENABLE   8'h18
`define ALFC_OFS_LOCK_STATUS  8'h1c

`define ALFC_RST_THIRD_POLE   8'h37
`define ALFC_RST_LOCK_CFG     16'h0180
`define ALFC_RST_THRESH       8'h88
`define ALFC_THIRD_POLE_MASK  8'hf7
`define ALFC_LOCK_CFG_MASK    16'h03ff

`define ALFC_TP_BYPASS        7
`define ALFC_TP_RES_HI        6
`define ALFC_TP_RES_LO        4
`define ALFC_TP_CAP_HI        2
`define ALFC_TP_CAP_LO        0

`define ALFC_LC_RAW_ROUTE     9
`define ALFC_LC_PRECISION     8
`define ALFC_LC_TIMER_HI      7
`define ALFC_LC_TIMER_LO      6
`define ALFC_LC_STICKY        5
`define ALFC_LC_CAL_GATE      4
`define ALFC_LC_DISABLE       3
`define ALFC_LC_FILT_HI       2
`define ALFC_LC_FILT_LO       0

`define ALFC_TH_HIGH_HI       7
`define ALFC_TH_HIGH_LO       4
`define ALFC_TH_LOW_HI        3
`define ALFC_TH_LOW_LO        0

`define ALFC_VC_FAIL          7
`define ALFC_VC_DONE          6

`define ALFC_IRQ_LOL          0

`define ALFC_CNT_W            16
`define ALFC_DEB_CYC_1        16'd570
`define ALFC_DEB_CYC_2        16'd5700
`define ALFC_DEB_CYC_3        16'd57000

`endif

// File: hdl/alfc_pkg.sv
// Purpose: shared types of the loop-filter and lock control block
// Assumes: constants live in alfc_map.svh
// Notes:   packed structs carry the analog trim groups
package alfc_pkg;

	typedef struct packed {
		logic       bypass;
		logic [2:0] resistor_sel;
		logic [2:0] capacitor_sel;
	} alfc_third_pole_t;

	typedef struct packed {
		logic       precision_en;
		logic [3:0] precision_high_threshold;
		logic [3:0] precision_low_threshold;
		logic [2:0] filter_res_sel;
		logic       detector_en;
	} alfc_lock_trim_t;

	typedef struct packed {
		logic       fail;
		logic       done;
		logic [5:0] band;
	} alfc_vco_cal_t;

	typedef enum logic [1:0] {
		ALFC_DEB_NONE,
		ALFC_DEB_SHORT,
		ALFC_DEB_MID,
		ALFC_DEB_LONG
	} alfc_deb_sel_t;

	typedef enum {
		ALFC_ST_UNLOCKED,
		ALFC_ST_COUNTING,
		ALFC_ST_LOCKED
	} alfc_lock_state_t;

endpackage

// File: hdl/alfc_ctrl.sv
// Purpose: control and status registers of an analog PLL loop filter and lock detector
// Assumes: raw lock and calibration inputs come from the analog side, asynchronous
// Notes:   one clock, asynchronous active-high reset
// Function
// - 3-bit third-pole resistor select, reset 0x3
// - 3-bit third-pole capacitor select, reset 0x7
// - raw-route bit puts undebounced selected lock on the status pin
// - precision enable, reset 1, chooses window-threshold lock detector
// - debounce interval 0, 570, 5700 or 57000 cycles, reset code 2
// - one-time select holds lock once asserted; else real-time
// - calibration gating: detector after calibration, or during and after
// - detector disable forces lock asserted
// - 3-bit lock-detect filter resistor select, reset 0
// - 4-bit precision low threshold, reset 0x8
// - 4-bit precision high threshold, reset 0x8
// - read-only calibration done bit
// - read-only calibration fail bit, valid when done
// - read-only 6-bit VCO band, valid when done
// - sticky loss-of-lock flag on locked-to-unlocked, write 1 clears
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "alfc_map.svh"

module alfc_ctrl
	import alfc_pkg::*;
(
	// clock and reset
	input  wire logic                     I_CLOCK,
	input  wire logic                     I_RST,
	// register port
	input  wire logic [`ALFC_ADDR_W-1:0]  I_ADDR,
	input  wire logic [31:0]              I_WDATA,
	input  wire logic                     I_WR,
	input  wire logic                     I_RD,
	output logic      [31:0]              O_RDATA,
	// analog lock detectors and calibration
	input  wire logic                     I_LOCK_ORIGINAL,
	input  wire logic                     I_LOCK_PRECISION,
	input  wire logic                     I_CAL_DONE,
	input  wire logic                     I_CAL_FAIL,
	input  wire logic [5:0]               I_CAL_BAND,
	// analog trims
	output alfc_third_pole_t              O_THIRD_POLE,
	output alfc_lock_trim_t               O_LOCK_TRIM,
	// lock and interrupt
	output logic                          O_LOCK,
	output logic                          O_IRQ
);

	logic [7:0]       third_pole_filter_cfg;
	logic [15:0]      lock_detector_cfg;
	logic [7:0]       lock_threshold_cfg;
	logic [7:0]       irq_enable;
	logic             lol_flag;
	logic [9:0]       sync_a;
	logic [9:0]       sync_b;
	logic             raw_sel;
	logic             det_enabled;
	logic             raw_qual;
	logic [`ALFC_CNT_W-1:0] deb_cnt;
	logic [`ALFC_CNT_W-1:0] deb_target;
	alfc_lock_state_t state;
	alfc_lock_state_t next_state;
	logic             proc_lock;
	logic             lock_status;
	logic             lock_status_d;
	logic             wr_hit_clear;
	alfc_vco_cal_t    vco_cal;

	function automatic logic hit(input logic [`ALFC_ADDR_W-1:0] a,
		input logic [`ALFC_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [`ALFC_CNT_W-1:0] deb_cycles(input logic [1:0] code);
		case (alfc_deb_sel_t'(code))
			ALFC_DEB_NONE:  deb_cycles = '0;
			ALFC_DEB_SHORT: deb_cycles = `ALFC_DEB_CYC_1;
			ALFC_DEB_MID:   deb_cycles = `ALFC_DEB_CYC_2;
			default:        deb_cycles = `ALFC_DEB_CYC_3;
		endcase
	endfunction

	// two-stage synchronisers for analog inputs
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {I_CAL_BAND, I_CAL_FAIL, I_CAL_DONE, I_LOCK_PRECISION, I_LOCK_ORIGINAL};
			sync_b <= sync_a;
		end
	end

	assign vco_cal.fail = sync_b[3];
	assign vco_cal.done = sync_b[2];
	assign vco_cal.band = sync_b[9:4];

	// third-pole register, writable fields only
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			third_pole_filter_cfg <= `ALFC_RST_THIRD_POLE;
		end else if (I_WR && hit(I_ADDR, `ALFC_OFS_THIRD_POLE)) begin
			third_pole_filter_cfg <= I_WDATA[7:0] & `ALFC_THIRD_POLE_MASK;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			lock_detector_cfg <= `ALFC_RST_LOCK_CFG;
		end else if (I_WR && hit(I_ADDR, `ALFC_OFS_LOCK_CFG)) begin
			lock_detector_cfg <= I_WDATA[15:0] & `ALFC_LOCK_CFG_MASK;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			lock_threshold_cfg <= `ALFC_RST_THRESH;
		end else if (I_WR && hit(I_ADDR, `ALFC_OFS_THRESH)) begin
			lock_threshold_cfg <= I_WDATA[7:0];
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			irq_enable <= '0;
		end else if (I_WR && hit(I_ADDR, `ALFC_OFS_IRQ_ENABLE)) begin
			irq_enable <= I_WDATA[7:0];
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_THIRD_POLE <= '0;
		end else begin
			O_THIRD_POLE.bypass        <= third_pole_filter_cfg[`ALFC_TP_BYPASS];
			O_THIRD_POLE.resistor_sel  <=
				third_pole_filter_cfg[`ALFC_TP_RES_HI:`ALFC_TP_RES_LO];
			O_THIRD_POLE.capacitor_sel <=
				third_pole_filter_cfg[`ALFC_TP_CAP_HI:`ALFC_TP_CAP_LO];
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_LOCK_TRIM <= '0;
		end else begin
			O_LOCK_TRIM.precision_en <= lock_detector_cfg[`ALFC_LC_PRECISION];
			O_LOCK_TRIM.precision_high_threshold <=
				lock_threshold_cfg[`ALFC_TH_HIGH_HI:`ALFC_TH_HIGH_LO];
			O_LOCK_TRIM.precision_low_threshold <=
				lock_threshold_cfg[`ALFC_TH_LOW_HI:`ALFC_TH_LOW_LO];
			O_LOCK_TRIM.filter_res_sel <=
				lock_detector_cfg[`ALFC_LC_FILT_HI:`ALFC_LC_FILT_LO];
			O_LOCK_TRIM.detector_en <= det_enabled;
		end
	end

	// precision window detector or original detector
	assign raw_sel = lock_detector_cfg[`ALFC_LC_PRECISION] ? sync_b[1] : sync_b[0];

	assign det_enabled = !lock_detector_cfg[`ALFC_LC_DISABLE] &&
		(lock_detector_cfg[`ALFC_LC_CAL_GATE] || vco_cal.done);
	assign raw_qual = det_enabled && raw_sel;

	assign deb_target = deb_cycles(lock_detector_cfg[`ALFC_LC_TIMER_HI:`ALFC_LC_TIMER_LO]);

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			deb_cnt <= '0;
		end else if (state == ALFC_ST_COUNTING && raw_qual) begin
			deb_cnt <= deb_cnt + `ALFC_CNT_W'(1);
		end else begin
			deb_cnt <= '0;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ALFC_ST_UNLOCKED: begin
				if (raw_qual) begin
					next_state = (deb_target == '0) ? ALFC_ST_LOCKED : ALFC_ST_COUNTING;
				end
			end
			ALFC_ST_COUNTING: begin
				if (!raw_qual) begin
					next_state = ALFC_ST_UNLOCKED;
				end else if (deb_cnt + `ALFC_CNT_W'(1) >= deb_target) begin
					next_state = ALFC_ST_LOCKED;
				end
			end
			ALFC_ST_LOCKED: begin
				if (!raw_qual && !lock_detector_cfg[`ALFC_LC_STICKY]) begin
					next_state = ALFC_ST_UNLOCKED;
				end
			end
			default: next_state = ALFC_ST_UNLOCKED;
		endcase
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			state <= ALFC_ST_UNLOCKED;
		end else begin
			state <= next_state;
		end
	end

	assign proc_lock = (state == ALFC_ST_LOCKED);

	assign lock_status = lock_detector_cfg[`ALFC_LC_DISABLE] || proc_lock;

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_LOCK <= 1'b0;
		end else if (lock_detector_cfg[`ALFC_LC_RAW_ROUTE]) begin
			O_LOCK <= raw_sel;
		end else begin
			O_LOCK <= lock_status;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			lock_status_d <= 1'b0;
		end else begin
			lock_status_d <= lock_status;
		end
	end

	assign wr_hit_clear = I_WR && hit(I_ADDR, `ALFC_OFS_IRQ_CLEAR) &&
		I_WDATA[`ALFC_IRQ_LOL];

	// sticky loss of lock, set beats clear
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			lol_flag <= 1'b0;
		end else if (lock_status_d && !lock_status) begin
			lol_flag <= 1'b1;
		end else if (wr_hit_clear) begin
			lol_flag <= 1'b0;
		end
	end

	assign O_IRQ = lol_flag && irq_enable[`ALFC_IRQ_LOL];

	// read data, one cycle after the strobe
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_RDATA <= '0;
		end else if (I_RD) begin
			case (I_ADDR)
				`ALFC_OFS_THIRD_POLE:  O_RDATA <= {24'h0, third_pole_filter_cfg};
				`ALFC_OFS_LOCK_CFG:    O_RDATA <= {16'h0, lock_detector_cfg};
				`ALFC_OFS_THRESH:      O_RDATA <= {24'h0, lock_threshold_cfg};
				`ALFC_OFS_VCO_CAL:     O_RDATA <= {24'h0, vco_cal};
				`ALFC_OFS_IRQ_STATUS:  O_RDATA <= {31'h0, lol_flag};
				`ALFC_OFS_IRQ_ENABLE:  O_RDATA <= {24'h0, irq_enable};
				`ALFC_OFS_LOCK_STATUS: O_RDATA <= {30'h0, raw_sel, lock_status};
				default:               O_RDATA <= '0;
			endcase
		end else begin
			O_RDATA <= '0;
		end
	end

endmodule

// File: testbench/alfc_ctrl_chk.sv
// Purpose: port assertions of the loop-filter and lock block
// Assumes: register offsets of alfc_map.svh
// Notes:   cfg mirrors the lock config register
`timescale 1ns/10ps

module alfc_ctrl_chk
	import alfc_pkg::*;
(
	// clock, reset and bus
	input wire logic             I_CLOCK,
	input wire logic             I_RST,
	input wire logic [7:0]       I_ADDR,
	input wire logic [31:0]      I_WDATA,
	input wire logic             I_WR,
	input wire logic             I_RD,
	input wire logic [31:0]      O_RDATA,
	// lock path
	input wire logic             I_LOCK_ORIGINAL,
	input wire logic             I_LOCK_PRECISION,
	input wire logic             I_CAL_DONE,
	input wire alfc_third_pole_t O_THIRD_POLE,
	input wire alfc_lock_trim_t  O_LOCK_TRIM,
	input wire logic             O_LOCK,
	input wire logic             O_IRQ
);
	logic [15:0] cfg;
	logic        irq_en;
	logic [16:0] run;
	wire  [16:0] lim = cfg[7:6] == 2'h3 ? 17'hdea8 : cfg[7:6] == 2'h2 ? 17'h1644 :
		cfg[7:6] == 2'h1 ? 17'h023a : 17'h0;
	wire         raw = cfg[8] ? I_LOCK_PRECISION : I_LOCK_ORIGINAL;
	wire         plain = !cfg[9] && !cfg[3];
	wire  [6:0]  tp_w = {I_WDATA[7:4], I_WDATA[2:0]};
	wire  [3:0]  lt_w = {I_WDATA[8], I_WDATA[2:0]};
	wire  [7:0]  th_w = I_WDATA[7:0];

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) cfg <= 16'h0180;
		else if (I_WR && I_ADDR == 8'h04) cfg <= I_WDATA[15:0];
	end
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) irq_en <= 1'h0;
		else if (I_WR && I_ADDR == 8'h18) irq_en <= I_WDATA[0];
	end
	// consecutive cycles of selected raw lock
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST || !raw) run <= 17'h0;
		else if (run != 17'h1ffff) run <= run + 17'h1;
	end

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	chk_rdata_slot: assert property (O_RDATA != 32'h0 |-> $past(I_RD))
		else $error("read data outside its slot");
	chk_pole_write: assert property (I_WR && I_ADDR == 8'h00 |-> ##2 O_THIRD_POLE == $past(tp_w, 2))
		else $error("third pole output wrong");
	chk_trim_write: assert property (I_WR && I_ADDR == 8'h04 |-> ##2
		{O_LOCK_TRIM.precision_en, O_LOCK_TRIM.filter_res_sel} == $past(lt_w, 2))
		else $error("lock trim output wrong");
	chk_thresh_write: assert property (I_WR && I_ADDR == 8'h08 |-> ##2 {O_LOCK_TRIM.precision_high_threshold,
		O_LOCK_TRIM.precision_low_threshold} == $past(th_w, 2))
		else $error("threshold output wrong");
	chk_raw_route: assert property ((cfg[9] && $stable(raw))[*4] |-> O_LOCK == raw)
		else $error("raw lock not routed");
	chk_disable_force: assert property (cfg[3] && $past(cfg[3]) && !cfg[9] && !$past(cfg[9]) |-> O_LOCK)
		else $error("disabled detector not forced locked");
	chk_deb_min: assert property ($rose(O_LOCK) && $past(plain) && !$past(cfg[9], 2) |-> run >= lim)
		else $error("lock before debounce interval");
	chk_sticky_hold: assert property (cfg[5] && $past(cfg[5]) && $past(O_LOCK) && plain && $past(plain)
		&& $past(plain, 2) |-> O_LOCK)
		else $error("one-time lock dropped");
	chk_gate_off: assert property ((!cfg[4] && !I_CAL_DONE && plain && !cfg[5])[*6] |-> !O_LOCK)
		else $error("lock during calibration");
	chk_lol_irq: assert property ($fell(O_LOCK) && irq_en && plain && !$past(cfg[9]) |-> ##[0:3] O_IRQ)
		else $error("loss of lock not flagged");
	chk_irq_mask: assert property (O_IRQ |-> irq_en)
		else $error("masked interrupt raised");

	cover property ($rose(O_LOCK));
	cover property ($rose(O_IRQ));
	cover property (cfg[9] && O_LOCK);
endmodule

bind alfc_ctrl alfc_ctrl_chk chk (.I_CLOCK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
	.I_LOCK_ORIGINAL, .I_LOCK_PRECISION, .I_CAL_DONE, .O_THIRD_POLE, .O_LOCK_TRIM, .O_LOCK, .O_IRQ);

// File: testbench/tb_top.sv
// Purpose: self-checking bench of the loop-filter and lock block
// Assumes: offsets as chosen in the register map
// Notes:   full debounce counts, longest near 57000 cycles
`timescale 1ns/10ps

module tb_top;
	logic                        I_CLOCK = 1'h0, I_RST = 1'h1, I_WR = 1'h0, I_RD = 1'h0;
	logic [7:0]                  I_ADDR = 8'h0;
	logic [31:0]                 I_WDATA = 32'h0, O_RDATA;
	logic                        I_LOCK_ORIGINAL = 1'h0, I_LOCK_PRECISION = 1'h0;
	logic                        I_CAL_DONE = 1'h0, I_CAL_FAIL = 1'h1, O_LOCK, O_IRQ;
	logic [5:0]                  I_CAL_BAND = 6'h2a;
	alfc_pkg::alfc_third_pole_t  O_THIRD_POLE;
	alfc_pkg::alfc_lock_trim_t   O_LOCK_TRIM;
	int                          error_cnt = 0, comparisons = 0, cycles = 0;

	alfc_ctrl uut (.I_CLOCK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_LOCK_ORIGINAL,
		.I_LOCK_PRECISION, .I_CAL_DONE, .I_CAL_FAIL, .I_CAL_BAND, .O_THIRD_POLE, .O_LOCK_TRIM,
		.O_LOCK, .O_IRQ);

	always #5 I_CLOCK = ~I_CLOCK;
	always @(posedge I_CLOCK) begin
		cycles++;
		if (cycles == 100000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLOCK);
		I_WR <= 1'h1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLOCK);
		I_WR <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge I_CLOCK);
		I_RD <= 1'h1;
		I_ADDR <= a;
		@(posedge I_CLOCK);
		I_RD <= 1'h0;
		#1 chk("rdata", O_RDATA, e);
	endtask
	task automatic wt(input logic v, output int k);
		k = 0;
		while (O_LOCK !== v && k < 60000) begin
			@(posedge I_CLOCK);
			#1 k++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge I_CLOCK);
		#1;
	endtask

	task automatic t_regs;
		rd(8'h00, 32'h37);
		rd(8'h04, 32'h180);
		rd(8'h08, 32'h88);
		rd(8'h0c, 32'haa);
		rd(8'h20, 32'h0);
		chk("pole", O_THIRD_POLE, 32'h1f);
		@(posedge I_CLOCK);
		I_CAL_DONE <= 1'h1;
		wr(8'h0c, 32'h0);
		rd(8'h0c, 32'hea);
		wr(8'h00, 32'hff);
		rd(8'h00, 32'hf7);
		chk("pole", O_THIRD_POLE, 32'h7f);
		wr(8'h08, 32'h3c);
		wr(8'h04, 32'hffff);
		rd(8'h08, 32'h3c);
		rd(8'h04, 32'h3ff);
		chk("trim", O_LOCK_TRIM, 32'h13ce);
		$display("register test done");
	endtask
	task automatic t_deb(input logic [1:0] c, input int len);
		int k;
		wr(8'h04, {22'h0, 2'h1, c, 6'h0});
		@(posedge I_CLOCK);
		I_LOCK_PRECISION <= 1'h0;
		cyc(8);
		@(posedge I_CLOCK);
		I_LOCK_PRECISION <= 1'h1;
		if (len > 0) begin
			cyc(len / 4);
			@(posedge I_CLOCK);
			I_LOCK_PRECISION <= 1'h0;
			cyc(2);
			@(posedge I_CLOCK);
			I_LOCK_PRECISION <= 1'h1;
		end
		wt(1'h1, k);
		chk("deb_len", k >= len + 1 && k <= len + 8, 32'h1);
		$display("debounce test done");
	endtask
	task automatic t_lol;
		int k;
		wr(8'h04, 32'h0);
		cyc(8);
		chk("orig_sel", O_LOCK, 32'h0);
		wr(8'h14, 32'h1);
		@(posedge I_CLOCK);
		I_LOCK_ORIGINAL <= 1'h1;
		wt(1'h1, k);
		wr(8'h18, 32'h1);
		rd(8'h10, 32'h0);
		@(posedge I_CLOCK);
		I_LOCK_ORIGINAL <= 1'h0;
		wt(1'h0, k);
		cyc(4);
		chk("irq", O_IRQ, 32'h1);
		wr(8'h14, 32'h0);
		rd(8'h10, 32'h1);
		wr(8'h14, 32'h1);
		rd(8'h10, 32'h0);
		wr(8'h18, 32'h0);
		wr(8'h04, 32'h108);
		wr(8'h04, 32'h100);
		cyc(6);
		chk("irq_mask", O_IRQ, 32'h0);
		rd(8'h10, 32'h1);
		$display("loss of lock test done");
	endtask
	task automatic t_mode;
		int k;
		wr(8'h04, 32'h120);
		wt(1'h1, k);
		@(posedge I_CLOCK);
		I_LOCK_PRECISION <= 1'h0;
		cyc(12);
		chk("sticky", O_LOCK, 32'h1);
		wr(8'h04, 32'h100);
		wt(1'h0, k);
		chk("realtime", k <= 8, 32'h1);
		wr(8'h04, 32'h108);
		cyc(3);
		chk("disable", O_LOCK, 32'h1);
		wr(8'h04, 32'h3c0);
		cyc(5);
		chk("route_lo", O_LOCK, 32'h0);
		@(posedge I_CLOCK);
		I_LOCK_PRECISION <= 1'h1;
		I_CAL_DONE <= 1'h0;
		cyc(5);
		chk("route_hi", O_LOCK, 32'h1);
		wr(8'h04, 32'h100);
		cyc(20);
		chk("gate", O_LOCK, 32'h0);
		wr(8'h04, 32'h110);
		wt(1'h1, k);
		chk("gate_byp", k <= 8, 32'h1);
		rd(8'h1c, 32'h3);
		$display("mode test done");
	endtask

	initial begin
		repeat (6) @(posedge I_CLOCK);
		I_RST <= 1'h0;
		t_regs();
		t_deb(2'h1, 570);
		t_deb(2'h2, 5700);
		t_deb(2'h3, 57000);
		t_deb(2'h0, 0);
		t_lol();
		t_mode();
		print_verdict();
	end
endmodule
